// ---- design/asw_defs.vh ----
// constants for the asynchronous sram word controller
//
// Behaviour
// - write only with both chip selects asserted and write strobe low; with SINGLE_SEL set the controller holds the second select low.
// - read needs selects asserted, output enable low, write strobe high throughout.
// - controller waits at least 100 us after power before first access.
// - controller deselects no later than 0 ns before retention supply level.
// - write ends when any of selects, strobe or lane select deasserts.
`ifndef ASW_DEFS_VH
`define ASW_DEFS_VH
`define ASW_ADDR_W        20
`define ASW_DATA_W        16
`define ASW_CLK_MHZ       50
`define ASW_POWER_US      100
`define ASW_POWER_CYC     (`ASW_POWER_US * `ASW_CLK_MHZ)
`define ASW_CYC_NS        20
`define ASW_ACCESS_NS     10
`define ASW_ACCESS_CYC    (((`ASW_ACCESS_NS + `ASW_CYC_NS - 1) / `ASW_CYC_NS) + 1)
`define ASW_WPULSE_NS     7
`define ASW_WPULSE_CYC    ((`ASW_WPULSE_NS + `ASW_CYC_NS - 1) / `ASW_CYC_NS)
`define ASW_DESEL_TO_RET_NS 0
`define ASW_SYNC_STAGES   2
`endif

// ---- design/asw_ctrl.v ----
// host controller driving an asynchronous 1M x 16 static memory
`timescale 1ns/1ns
`default_nettype none
`include "asw_defs.vh"
module asw_ctrl #(
  parameter POWER_CYC = `ASW_POWER_CYC,
  parameter SINGLE_SEL = 0
) (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        req_i,
  input  wire        req_write_i,
  input  wire [19:0] req_addr_i,
  input  wire [15:0] req_wdata_i,
  input  wire [1:0]  req_lane_n_i,
  input  wire        retain_i,
  output reg         ready_o,
  output reg         done_o,
  output reg  [15:0] rdata_o,
  output reg  [19:0] mem_addr_o,
  output reg         mem_sel1_n_o,
  output reg         mem_sel2_o,
  output reg         mem_we_n_o,
  output reg         mem_oe_n_o,
  output reg         lower_lane_select_n_o,
  output reg         upper_lane_select_n_o,
  output reg  [15:0] mem_dq_o,
  output reg  [15:0] mem_dq_oe_n_o,
  input  wire [15:0] mem_dq_i
);
  localparam ST_POWER = 3'h0;
  localparam ST_IDLE  = 3'h1;
  localparam ST_WR    = 3'h2;
  localparam ST_WEND  = 3'h3;
  localparam ST_RD    = 3'h4;
  localparam ST_RET   = 3'h5;
  localparam integer ACC_CYC_I = `ASW_ACCESS_CYC;
  localparam integer WP_CYC_I  = `ASW_WPULSE_CYC;
  localparam integer SYNC_I    = `ASW_SYNC_STAGES;
  localparam [3:0]   ACC_CYC   = ACC_CYC_I[3:0];
  localparam [3:0]   WP_CYC    = WP_CYC_I[3:0];
  // read data passes the pin synchroniser before it is sampled
  localparam [3:0]   RD_LAST   = ACC_CYC + SYNC_I[3:0];
  localparam [31:0]  PWR_LAST  = POWER_CYC - 1;

  reg [2:0]  st_q;
  reg [31:0] pwr_q;
  reg [3:0]  cnt_q;
  reg [15:0] dq_s1_q;
  reg [15:0] dq_s2_q;
  reg        ret_s1_q;
  reg        ret_s2_q;
  reg [1:0]  lane_q;
  reg        rst_n_s1_q;
  reg        rst_n_s2_q;

  // read byte as seen on the pins, zero when that lane was not selected
  function [7:0] lane_pick;
    input       sel_n;
    input [7:0] bits;
    begin
      lane_pick = sel_n ? 8'h00 : bits;
    end
  endfunction

  // per-bit drive enables; a masked lane stays released during a write
  function [15:0] lane_oe_n;
    input [1:0] sel_n;
    begin
      lane_oe_n = {{8{sel_n[1]}}, {8{sel_n[0]}}};
    end
  endfunction

  // release reset on a clock edge so no flop sees it inside its recovery window
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_n_s1_q <= 1'b0;
      rst_n_s2_q <= 1'b0;
    end else begin
      rst_n_s1_q <= 1'b1;
      rst_n_s2_q <= rst_n_s1_q;
    end
  end

  // data pins are asynchronous to our clock
  always @(posedge sys_clk_i or negedge rst_n_s2_q) begin
    if (!rst_n_s2_q) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // retention request comes from the supply monitor, not from our clock
  always @(posedge sys_clk_i or negedge rst_n_s2_q) begin
    if (!rst_n_s2_q) begin
      ret_s1_q <= 1'b0;
      ret_s2_q <= 1'b0;
    end else begin
      ret_s1_q <= retain_i;
      ret_s2_q <= ret_s1_q;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_s2_q) begin
    if (!rst_n_s2_q) begin
      st_q                  <= ST_POWER;
      pwr_q                 <= 32'h00000000;
      cnt_q                 <= 4'h0;
      lane_q                <= 2'h3;
      ready_o               <= 1'b0;
      done_o                <= 1'b0;
      rdata_o               <= 16'h0000;
      mem_addr_o            <= 20'h00000;
      mem_sel1_n_o          <= 1'b1;
      mem_sel2_o            <= 1'b0;
      mem_we_n_o            <= 1'b1;
      mem_oe_n_o            <= 1'b1;
      lower_lane_select_n_o <= 1'b1;
      upper_lane_select_n_o <= 1'b1;
      mem_dq_o              <= 16'h0000;
      mem_dq_oe_n_o         <= 16'hFFFF;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        ST_POWER: begin
          // no access before the power-up wait expires
          if (pwr_q >= PWR_LAST) begin
            st_q    <= ST_IDLE;
            ready_o <= 1'b1;
          end else begin
            pwr_q <= pwr_q + 32'h00000001;
          end
        end
        ST_IDLE: begin
          if (ret_s2_q) begin
            // already deselected here, so retention is safe at once
            st_q    <= ST_RET;
            ready_o <= 1'b0;
          end else if (req_i) begin
            ready_o               <= 1'b0;
            mem_addr_o            <= req_addr_i;
            lane_q                <= req_lane_n_i;
            mem_sel1_n_o          <= 1'b0;
            mem_sel2_o            <= (SINGLE_SEL != 0) ? 1'b0 : 1'b1;
            lower_lane_select_n_o <= req_lane_n_i[0];
            upper_lane_select_n_o <= req_lane_n_i[1];
            cnt_q                 <= 4'h0;
            if (req_write_i) begin
              st_q          <= ST_WR;
              mem_we_n_o    <= 1'b0;
              mem_oe_n_o    <= 1'b1;
              mem_dq_o      <= req_wdata_i;
              // drive only the lanes being written
              mem_dq_oe_n_o <= lane_oe_n(req_lane_n_i);
            end else begin
              st_q          <= ST_RD;
              mem_we_n_o    <= 1'b1;
              mem_oe_n_o    <= 1'b0;
              mem_dq_oe_n_o <= 16'hFFFF;
            end
          end
        end
        ST_WR: begin
          if (cnt_q >= WP_CYC) begin
            // strobe rises first; data held a cycle past the end
            st_q       <= ST_WEND;
            mem_we_n_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_WEND: begin
          st_q                  <= ST_IDLE;
          mem_dq_oe_n_o         <= 16'hFFFF;
          mem_sel1_n_o          <= 1'b1;
          mem_sel2_o            <= 1'b0;
          lower_lane_select_n_o <= 1'b1;
          upper_lane_select_n_o <= 1'b1;
          done_o                <= 1'b1;
          ready_o               <= 1'b1;
        end
        ST_RD: begin
          // two sync stages added to access time before sampling
          if (cnt_q >= RD_LAST) begin
            st_q                  <= ST_IDLE;
            rdata_o[7:0]          <= lane_pick(lane_q[0], dq_s2_q[7:0]);
            rdata_o[15:8]         <= lane_pick(lane_q[1], dq_s2_q[15:8]);
            mem_oe_n_o            <= 1'b1;
            mem_sel1_n_o          <= 1'b1;
            mem_sel2_o            <= 1'b0;
            lower_lane_select_n_o <= 1'b1;
            upper_lane_select_n_o <= 1'b1;
            done_o                <= 1'b1;
            ready_o               <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_RET: begin
          // hold every strobe off while the supply may sit at retention level
          mem_sel1_n_o  <= 1'b1;
          mem_sel2_o    <= 1'b0;
          mem_we_n_o    <= 1'b1;
          mem_oe_n_o    <= 1'b1;
          mem_dq_oe_n_o <= 16'hFFFF;
          if (!ret_s2_q) begin
            st_q    <= ST_IDLE;
            ready_o <= 1'b1;
          end
        end
        default: begin
          // an unused code falls back to a deselected, idle bus
          st_q          <= ST_IDLE;
          ready_o       <= 1'b1;
          mem_sel1_n_o  <= 1'b1;
          mem_sel2_o    <= 1'b0;
          mem_we_n_o    <= 1'b1;
          mem_oe_n_o    <= 1'b1;
          mem_dq_oe_n_o <= 16'hFFFF;
        end
      endcase
    end
  end
  // is a device duty; we never deselect with strobe rising together
endmodule // asw_ctrl
`default_nettype wire

// ---- sim/asw_ctrl_checker.sv ----
// pin assertions for the static memory controller
`timescale 1ns/1ns
`default_nettype none
module asw_ctrl_checker #(
  parameter int SINGLE_SEL = 0
) (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        done_o,
  input wire logic        ready_o,
  input wire logic        mem_sel1_n_o,
  input wire logic        mem_sel2_o,
  input wire logic        mem_we_n_o,
  input wire logic        mem_oe_n_o,
  input wire logic [15:0] mem_dq_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // the single-select variant ignores the second select
  wire sel = !mem_sel1_n_o && (SINGLE_SEL != 0 || mem_sel2_o);
  logic up_q;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_q <= 1'b0;
    end else if (ready_o) begin
      up_q <= 1'b1;
    end
  end
  sequence s_wr_low; !mem_we_n_o ##1 mem_we_n_o; endsequence
  sequence s_rd_open; !mem_oe_n_o [*5]; endsequence
  sequence s_rd_close; done_o && mem_oe_n_o && !sel; endsequence
  a_we_in_sel: assert property (!mem_we_n_o |-> sel)
    else $error("strobe while deselected");
  a_no_overlap: assert property (!(!mem_we_n_o && !mem_oe_n_o))
    else $error("strobe and enable both low");
  a_drive_safe: assert property (mem_dq_oe_n_o != 16'hFFFF |-> sel && mem_oe_n_o)
    else $error("data driven outside write");
  a_wr_pulse: assert property ($fell(mem_we_n_o) |=> s_wr_low)
    else $error("write pulse length");
  a_wr_hold: assert property ($rose(mem_we_n_o) |-> sel && mem_dq_oe_n_o != 16'hFFFF)
    else $error("no data hold");
  a_wr_end: assert property ($rose(mem_we_n_o) |=> !sel && done_o && &mem_dq_oe_n_o)
    else $error("write end");
  a_rd_len: assert property ($fell(mem_oe_n_o) |-> s_rd_open ##1 s_rd_close)
    else $error("read length");
  a_idle_desel: assert property (ready_o |-> !sel)
    else $error("idle but selected");
  a_power_wait: assert property (!up_q |-> mem_sel1_n_o && mem_we_n_o && mem_oe_n_o)
    else $error("access before power wait");
endmodule // asw_ctrl_checker
bind asw_ctrl asw_ctrl_checker #(.SINGLE_SEL(SINGLE_SEL)) u_asw_ctrl_checker (.sys_clk_i,
  .nrst_i, .done_o, .ready_o, .mem_sel1_n_o, .mem_sel2_o, .mem_we_n_o, .mem_oe_n_o,
  .mem_dq_oe_n_o);
`default_nettype wire

// ---- sim/asw_sram_model.sv ----
// behavioural 1M x 16 static memory
`timescale 1ns/1ns
`default_nettype none
module asw_sram_model #(
  parameter int SINGLE_SEL = 0
) (
  input  wire logic        clk_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        sel1_n_i,
  input  wire logic        sel2_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        hi_n_i,
  input  wire logic [15:0] hd_i,
  input  wire logic [15:0] hd_oe_n_i,
  output wire logic [15:0] bus_o
);
  logic [15:0] mem_q [0:1048575];
  logic [15:0] flt_q = 16'h5A5A;
  wire sel = !sel1_n_i && (SINGLE_SEL != 0 || sel2_i);
  wire [15:0] rd = {{8{!hi_n_i}}, {8{!lo_n_i}}} & {16{sel && !oe_n_i && we_n_i}};
  // floating lines toggle so a stale value cannot pass
  always @(posedge clk_i) flt_q <= ~flt_q;
  always @* if (sel && !we_n_i) begin
    if (!lo_n_i) mem_q[addr_i][7:0] = hd_i[7:0];
    if (!hi_n_i) mem_q[addr_i][15:8] = hd_i[15:8];
  end
  assign bus_o = (~hd_oe_n_i & hd_i) | (hd_oe_n_i & rd & mem_q[addr_i]) | (hd_oe_n_i & ~rd & flt_q);
endmodule // asw_sram_model
`default_nettype wire

// ---- sim/asw_ctrl_tb.sv ----
// self-checking bench for the static memory controller
`timescale 1ns/1ns
`default_nettype none
module asw_ctrl_tb;
  logic sys_clk_i = 0, nrst_i = 0, req_i = 0, req_write_i = 0, retain_i = 0, ready_o, done_o;
  logic mem_sel1_n_o, mem_sel2_o, mem_we_n_o, mem_oe_n_o, lower_lane_select_n_o, upper_lane_select_n_o;
  logic [19:0] req_addr_i = 0, mem_addr_o;
  logic [15:0] req_wdata_i = 0, rdata_o, mem_dq_o, mem_dq_oe_n_o;
  logic [1:0] req_lane_n_i = 0;
  wire [15:0] mem_dq_i;
  int err_total = 0, total_checks = 0;
  localparam int PWR_CYC = 10;
  asw_ctrl #(.POWER_CYC(PWR_CYC)) u_asw_ctrl (.sys_clk_i, .nrst_i, .req_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_lane_n_i, .retain_i, .ready_o, .done_o, .rdata_o, .mem_addr_o,
    .mem_sel1_n_o, .mem_sel2_o, .mem_we_n_o, .mem_oe_n_o, .lower_lane_select_n_o,
    .upper_lane_select_n_o, .mem_dq_o, .mem_dq_oe_n_o, .mem_dq_i);
  asw_sram_model u_asw_sram_model (.clk_i(sys_clk_i), .addr_i(mem_addr_o),
    .sel1_n_i(mem_sel1_n_o), .sel2_i(mem_sel2_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o),
    .lo_n_i(lower_lane_select_n_o), .hi_n_i(upper_lane_select_n_o), .hd_i(mem_dq_o),
    .hd_oe_n_i(mem_dq_oe_n_o), .bus_o(mem_dq_i));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task acc(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
    int n;
    for (n = 0; ready_o !== 1'b1 && n < 50; n++) @(negedge sys_clk_i);
    {req_i, req_write_i, req_addr_i, req_wdata_i, req_lane_n_i} = {1'b1, w, a, d, l};
    @(negedge sys_clk_i);
    req_i = 0;
    for (n = 0; done_o !== 1'b1 && n < 20; n++) @(negedge sys_clk_i);
    chk("done", {15'h0, done_o}, 16'h0001);
  endtask
  task s_power;
    chk("ready early", {15'h0, ready_o}, 16'h0000);
    // power count plus two reset-release stages, minus the edge already seen
    repeat (PWR_CYC + 1) @(negedge sys_clk_i);
    chk("ready wait", {15'h0, ready_o}, 16'h0000);
    @(negedge sys_clk_i);
    chk("ready late", {15'h0, ready_o}, 16'h0001);
  endtask
  task s_lanes;
    acc(1, 20'hFFFFF, 16'h1234, 2'b00);
    acc(1, 20'hFFFFF, 16'hFFAB, 2'b10);
    acc(1, 20'hFFFFF, 16'hCDFF, 2'b01);
    acc(0, 20'hFFFFF, 16'h0000, 2'b00);
    chk("word", rdata_o, 16'hCDAB);
    acc(0, 20'hFFFFF, 16'h0000, 2'b10);
    chk("lower", rdata_o, 16'h00AB);
    acc(0, 20'hFFFFF, 16'h0000, 2'b01);
    chk("upper", rdata_o, 16'hCD00);
  endtask
  task s_retain;
    acc(1, 20'h00000, 16'h8001, 2'b00);
    retain_i = 1;
    repeat (8) @(negedge sys_clk_i);
    chk("retain desel", {15'h0, mem_sel1_n_o}, 16'h0001);
    chk("retain busy", {15'h0, ready_o}, 16'h0000);
    req_i = 1;
    repeat (2) @(negedge sys_clk_i);
    chk("retain refuse", {15'h0, mem_we_n_o}, 16'h0001);
    chk("retain unsel", {15'h0, mem_sel1_n_o}, 16'h0001);
    req_i = 0;
    retain_i = 0;
    acc(0, 20'h00000, 16'h0000, 2'b00);
    chk("retained", rdata_o, 16'h8001);
    acc(0, 20'hFFFFF, 16'h0000, 2'b00);
    chk("other word", rdata_o, 16'hCDAB);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_i);
    nrst_i = 1;
    s_power;
    s_lanes;
    s_retain;
    results;
  end
  initial begin
    #20000;
    err_total++;
    results;
  end
endmodule // asw_ctrl_tb
`default_nettype wire
